// ===== ambient_threshold_indicator_blink.sv
/*
 * Register bank for two ambient light comparators with hysteresis and
 * three blinking indicator sinks, reached over a byte register port.
 * Assumes the serial interface engine presents one-cycle read and write
 * strobes with an address, and that the light code is synchronous to clk.
 */
`timescale 1ns/10ps
`include "ambient_defs.svh"

module ambient_threshold_indicator_blink #(
	parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_S  // Clock cycles per millisecond.
) (
	input  wire logic                 clk,             // System clock, 10 MHz.
	input  wire logic                 arst_n,          // Asynchronous reset, active low.
	input  wire logic [7:0]           reg_addr,        // Register offset.
	input  wire logic [7:0]           reg_wdata,       // Write data.
	input  wire logic                 reg_write,       // Write strobe, one cycle.
	input  wire logic                 reg_read,        // Read strobe, one cycle.
	output logic      [7:0]           reg_rdata,       // Read data, next cycle.
	input  wire logic [`LIGHT_W-1:0]  light_code,      // Ambient light, 0.5 uA per code.
	output logic                      office_level_flag, // Light is at office level.
	output logic                      dark_level_flag, // Light is at dark level.
	output logic      [2:0]           sink_drive,      // Indicator sinks lit.
	output logic                      fade_law_select, // 0 linear, 1 square fade.
	output logic      [3:0]           fade_in_time,    // Fade-in code, 0 disables.
	output logic      [3:0]           fade_out_time    // Fade-out code, 0 disables.
);

	// ****************************************************************
	// Derived scale and timing constants.
	// ****************************************************************

	// Light input steps per trip code for each comparator.
	localparam int OFFICE_RATIO = `OFFICE_STEP_NA / `SENSOR_STEP_NA;
	localparam int DARK_RATIO   = `DARK_STEP_NA / `SENSOR_STEP_NA;
	localparam logic [`PRESCALE_W-1:0] PRESCALE_LAST = `PRESCALE_W'(CYCLES_PER_MS - 1);

	ambient_pkg::bank_state_t state_ff;
	ambient_pkg::bank_state_t nxt_state;

	logic [`LIGHT_W-1:0] office_set_level;
	logic [`LIGHT_W-1:0] office_clr_level;
	logic [`LIGHT_W-1:0] dark_set_level;
	logic [`LIGHT_W-1:0] dark_clr_level;
	logic [`MS_W-1:0]    on_ms;
	logic [`MS_W-1:0]    off_ms [3];
	logic [2:0]          lit;

	// ****************************************************************
	// Timing code decode.
	// ****************************************************************

	// Shared on-time code to milliseconds.
	function automatic logic [`MS_W-1:0] on_code_ms(input logic [1:0] code);
		logic [`MS_W-1:0] ms;
		ms = `MS_W'(`ON_TIME0_MS);
		case (code)
			2'h1: ms = `MS_W'(`ON_TIME1_MS);
			2'h2: ms = `MS_W'(`ON_TIME2_MS);
			2'h3: ms = `MS_W'(`ON_TIME3_MS);
			default: ms = `MS_W'(`ON_TIME0_MS);
		endcase
		return ms;
	endfunction

	// Off-time code to milliseconds; zero means steady on.
	function automatic logic [`MS_W-1:0] off_code_ms(input logic [1:0] code);
		logic [`MS_W-1:0] ms;
		ms = `MS_W'(`OFF_NONE_MS);
		case (code)
			2'h1: ms = `MS_W'(`OFF_TIME1_MS);
			2'h2: ms = `MS_W'(`OFF_TIME2_MS);
			2'h3: ms = `MS_W'(`OFF_TIME3_MS);
			default: ms = `MS_W'(`OFF_NONE_MS);
		endcase
		return ms;
	endfunction

	// Decode the shared on-time and the three off-times.
	always_comb begin
		on_ms = on_code_ms(state_ff.blink_times[`MSB_SHARED_ON_TIME:`LSB_SHARED_ON_TIME]);
		off_ms[2] = off_code_ms(state_ff.blink_times[`LSB_SINK2_OFF_TIME +: 2]);
		off_ms[1] = off_code_ms(state_ff.blink_times[`LSB_SINK1_OFF_TIME +: 2]);
		off_ms[0] = off_code_ms(state_ff.blink_times[`LSB_SINK0_OFF_TIME +: 2]);
	end

	// ****************************************************************
	// Comparator thresholds in light input steps.
	// ****************************************************************

	// Scale the trip point and trip plus hysteresis to the input steps.
	assign office_set_level = `LIGHT_W'(OFFICE_RATIO) * `LIGHT_W'(state_ff.office_trip);
	assign office_clr_level = `LIGHT_W'(OFFICE_RATIO)
		* (`LIGHT_W'(state_ff.office_trip) + `LIGHT_W'(state_ff.office_hys));
	assign dark_set_level   = `LIGHT_W'(DARK_RATIO) * `LIGHT_W'(state_ff.dark_trip);
	assign dark_clr_level   = `LIGHT_W'(DARK_RATIO)
		* (`LIGHT_W'(state_ff.dark_trip) + `LIGHT_W'(state_ff.dark_hys));

	// ****************************************************************
	// Next-state logic: prescaler, comparators, register port.
	// ****************************************************************

	always_comb begin
		nxt_state = state_ff;

		// Millisecond prescaler paces every blink sequencer.
		nxt_state.ms_tick = 1'b0;
		if (state_ff.prescale >= PRESCALE_LAST) begin
			nxt_state.prescale = '0;
			nxt_state.ms_tick = 1'b1;
		end else begin
			nxt_state.prescale = state_ff.prescale + `PRESCALE_W'(1);
		end

		// Office comparator: set below trip, clear above trip plus hysteresis.
		if (!state_ff.cmp_enable[`BIT_OFFICE_ENABLE]) begin
			nxt_state.office_flag = 1'b0;
		end else if (light_code < office_set_level) begin
			nxt_state.office_flag = 1'b1;
		end else if (light_code > office_clr_level) begin
			nxt_state.office_flag = 1'b0;
		end

		// Dark comparator, same shape on the finer scale.
		if (!state_ff.cmp_enable[`BIT_DARK_ENABLE]) begin
			nxt_state.dark_flag = 1'b0;
		end else if (light_code < dark_set_level) begin
			nxt_state.dark_flag = 1'b1;
		end else if (light_code > dark_clr_level) begin
			nxt_state.dark_flag = 1'b0;
		end

		// Register writes keep only the documented bits.
		if (reg_write) begin
			if (reg_addr == `OFS_COMPARATOR_CONFIG) begin
				nxt_state.cmp_enable = reg_wdata[`BIT_DARK_ENABLE:`BIT_OFFICE_ENABLE];
			end else if (reg_addr == `OFS_OFFICE_TRIP_LEVEL) begin
				nxt_state.office_trip = reg_wdata[6:0];
			end else if (reg_addr == `OFS_OFFICE_HYSTERESIS) begin
				nxt_state.office_hys = reg_wdata[6:0];
			end else if (reg_addr == `OFS_DARK_TRIP_LEVEL) begin
				nxt_state.dark_trip = reg_wdata[6:0];
			end else if (reg_addr == `OFS_DARK_HYSTERESIS) begin
				nxt_state.dark_hys = reg_wdata[6:0];
			end else if (reg_addr == `OFS_INDICATOR_SINK_CONTROL) begin
				nxt_state.fade_law = reg_wdata[`BIT_FADE_LAW];
				nxt_state.sink_enable = reg_wdata[`MSB_SINK_ENABLE:0];
			end else if (reg_addr == `OFS_INDICATOR_BLINK_TIMES) begin
				nxt_state.blink_times = reg_wdata;
			end else if (reg_addr == `OFS_INDICATOR_FADE_TIMES) begin
				nxt_state.fade_times = reg_wdata;
			end
		end

		// Register reads: unused bits and unmapped offsets read zero.
		if (reg_read) begin
			if (reg_addr == `OFS_COMPARATOR_CONFIG) begin
				nxt_state.rdata = {4'h0, state_ff.dark_flag, state_ff.office_flag,
					state_ff.cmp_enable};
			end else if (reg_addr == `OFS_OFFICE_TRIP_LEVEL) begin
				nxt_state.rdata = {1'b0, state_ff.office_trip};
			end else if (reg_addr == `OFS_OFFICE_HYSTERESIS) begin
				nxt_state.rdata = {1'b0, state_ff.office_hys};
			end else if (reg_addr == `OFS_DARK_TRIP_LEVEL) begin
				nxt_state.rdata = {1'b0, state_ff.dark_trip};
			end else if (reg_addr == `OFS_DARK_HYSTERESIS) begin
				nxt_state.rdata = {1'b0, state_ff.dark_hys};
			end else if (reg_addr == `OFS_INDICATOR_SINK_CONTROL) begin
				nxt_state.rdata = {4'h0, state_ff.fade_law, state_ff.sink_enable};
			end else if (reg_addr == `OFS_INDICATOR_BLINK_TIMES) begin
				nxt_state.rdata = state_ff.blink_times;
			end else if (reg_addr == `OFS_INDICATOR_FADE_TIMES) begin
				nxt_state.rdata = state_ff.fade_times;
			end else begin
				nxt_state.rdata = `RST_BYTE;
			end
		end
	end

	// ****************************************************************
	// State register.
	// ****************************************************************

	// All control state resets to zero: comparators off, sinks dark.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '{
				office_trip: `RST_LEVEL,
				office_hys:  `RST_LEVEL,
				dark_trip:   `RST_LEVEL,
				dark_hys:    `RST_LEVEL,
				cmp_enable:  `RST_ENABLES,
				office_flag: 1'b0,
				dark_flag:   1'b0,
				fade_law:    1'b0,
				sink_enable: 3'h0,
				blink_times: `RST_BYTE,
				fade_times:  `RST_BYTE,
				prescale:    '0,
				ms_tick:     1'b0,
				rdata:       `RST_BYTE
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// Indicator blink sequencers.
	// ****************************************************************

	// One sequencer per sink, all sharing the on-time and the tick.
	for (genvar i = 0; i < 3; i++) begin : g_sink
		blink_sequencer u_seq (
			.clk         (clk),
			.arst_n      (arst_n),
			.sink_enable (state_ff.sink_enable[i]),
			.ms_tick     (state_ff.ms_tick),
			.on_ms       (on_ms),
			.off_ms      (off_ms[i]),
			.lit         (lit[i])
		);
	end

	// ****************************************************************
	// Outputs, all straight from flip-flops.
	// ****************************************************************

	assign reg_rdata         = state_ff.rdata;
	assign office_level_flag = state_ff.office_flag;
	assign dark_level_flag   = state_ff.dark_flag;
	assign sink_drive        = lit;
	assign fade_law_select   = state_ff.fade_law;
	assign fade_in_time      = state_ff.fade_times[3:0];
	assign fade_out_time     = state_ff.fade_times[7:4];

endmodule

// ===== ambient_defs.svh
/*
 * Constants for the ambient threshold and indicator blink register bank:
 * register offsets, field positions, reset values and timing figures.
 * Assumes it is included by its bare name; holds definitions only.
 */
`ifndef AMBIENT_DEFS_SVH
`define AMBIENT_DEFS_SVH

// ****************************************************************
// Register offsets on the byte register port.
// ****************************************************************
`define OFS_COMPARATOR_CONFIG      8'h0c
`define OFS_OFFICE_TRIP_LEVEL      8'h0d
`define OFS_OFFICE_HYSTERESIS      8'h0e
`define OFS_DARK_TRIP_LEVEL        8'h0f
`define OFS_DARK_HYSTERESIS        8'h10
`define OFS_INDICATOR_SINK_CONTROL 8'h11
`define OFS_INDICATOR_BLINK_TIMES  8'h12
`define OFS_INDICATOR_FADE_TIMES   8'h13

// ****************************************************************
// Field positions.
// ****************************************************************
`define BIT_OFFICE_ENABLE    0
`define BIT_DARK_ENABLE      1
`define BIT_OFFICE_FLAG      2
`define BIT_DARK_FLAG        3
`define BIT_FADE_LAW         3
`define MSB_SINK_ENABLE      2
`define MSB_SHARED_ON_TIME   7
`define LSB_SHARED_ON_TIME   6
`define LSB_SINK2_OFF_TIME   4
`define LSB_SINK1_OFF_TIME   2
`define LSB_SINK0_OFF_TIME   0

// ****************************************************************
// Reset values and widths.
// ****************************************************************
`define RST_LEVEL   7'h00
`define RST_BYTE    8'h00
`define RST_NIBBLE  4'h0
`define RST_ENABLES 2'h0
`define MS_W        11
`define PRESCALE_W  24

// ****************************************************************
// Sensor scale: the light input counts 0.5 uA steps, the office
// trip and hysteresis count 4 uA steps, the dark ones 0.5 uA steps.
// ****************************************************************
`define LIGHT_W            12
`define SENSOR_STEP_NA     500
`define OFFICE_STEP_NA     4000
`define DARK_STEP_NA       500
`define OFFICE_FULL_UA     1000
`define DARK_FULL_UA       127

// ****************************************************************
// Timing figures in milliseconds and the clock rate.
// ****************************************************************
`define CLK_HZ        10000000
`define MS_PER_S      1000
`define ON_TIME0_MS   200
`define ON_TIME1_MS   600
`define ON_TIME2_MS   800
`define ON_TIME3_MS   1200
`define OFF_TIME1_MS  600
`define OFF_TIME2_MS  800
`define OFF_TIME3_MS  1200
`define OFF_NONE_MS   0

`endif

// ===== ambient_pkg.sv
/*
 * Types for the ambient threshold and indicator blink register bank.
 * Assumes ambient_defs.svh is on the include path.
 */
`include "ambient_defs.svh"

package ambient_pkg;

	// One-hot phases of a single indicator blink sequencer.
	typedef enum logic [2:0] {
		PH_IDLE = 3'h1,
		PH_ON   = 3'h2,
		PH_OFF  = 3'h4
	} blink_phase_t;

	// State of one blink sequencer.
	typedef struct packed {
		blink_phase_t            phase;
		logic [`MS_W-1:0]        ms_count;
		logic                    lit;
	} blink_state_t;

	// State of the register bank.
	typedef struct packed {
		logic [6:0]              office_trip;
		logic [6:0]              office_hys;
		logic [6:0]              dark_trip;
		logic [6:0]              dark_hys;
		logic [1:0]              cmp_enable;
		logic                    office_flag;
		logic                    dark_flag;
		logic                    fade_law;
		logic [2:0]              sink_enable;
		logic [7:0]              blink_times;
		logic [7:0]              fade_times;
		logic [`PRESCALE_W-1:0]  prescale;
		logic                    ms_tick;
		logic [7:0]              rdata;
	} bank_state_t;

endpackage

// ===== blink_sequencer.sv
/*
 * One indicator blink sequencer: alternates the shared on-time with
 * this sink's own off-time while the sink is enabled.
 * Assumes a one-cycle millisecond tick from the register bank.
 */
`timescale 1ns/10ps
`include "ambient_defs.svh"

module blink_sequencer (
	input  wire logic                clk,          // System clock.
	input  wire logic                arst_n,       // Asynchronous reset, active low.
	input  wire logic                sink_enable,  // Sink enable bit.
	input  wire logic                ms_tick,      // One pulse per millisecond.
	input  wire logic [`MS_W-1:0]    on_ms,        // Shared on-time in ms.
	input  wire logic [`MS_W-1:0]    off_ms,       // Off-time in ms, zero for steady.
	output logic                     lit           // Sink is driven.
);

	ambient_pkg::blink_state_t state_ff;
	ambient_pkg::blink_state_t nxt_state;

	// ****************************************************************
	// Phase sequencing.
	// ****************************************************************

	// Enabling starts in the on phase; a zero off-time keeps it there.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff.phase)
			ambient_pkg::PH_IDLE: begin
				nxt_state.ms_count = '0;
				if (sink_enable) begin
					nxt_state.phase = ambient_pkg::PH_ON;
				end
			end
			ambient_pkg::PH_ON: begin
				if (ms_tick) begin
					nxt_state.ms_count = state_ff.ms_count + `MS_W'(1);
					if (state_ff.ms_count + `MS_W'(1) >= on_ms) begin
						nxt_state.ms_count = '0;
						if (off_ms != `MS_W'(`OFF_NONE_MS)) begin
							nxt_state.phase = ambient_pkg::PH_OFF;
						end
					end
				end
				if (off_ms == `MS_W'(`OFF_NONE_MS)) begin
					nxt_state.ms_count = '0;
				end
			end
			ambient_pkg::PH_OFF: begin
				if (off_ms == `MS_W'(`OFF_NONE_MS)) begin
					nxt_state.ms_count = '0;
					nxt_state.phase = ambient_pkg::PH_ON;
				end else if (ms_tick) begin
					nxt_state.ms_count = state_ff.ms_count + `MS_W'(1);
					if (state_ff.ms_count + `MS_W'(1) >= off_ms) begin
						nxt_state.ms_count = '0;
						nxt_state.phase = ambient_pkg::PH_ON;
					end
				end
			end
			default: begin
				nxt_state.phase = ambient_pkg::PH_IDLE;
				nxt_state.ms_count = '0;
			end
		endcase
		if (!sink_enable) begin
			nxt_state.phase = ambient_pkg::PH_IDLE;
			nxt_state.ms_count = '0;
		end
		nxt_state.lit = (nxt_state.phase == ambient_pkg::PH_ON);
	end

	// State register.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '{phase: ambient_pkg::PH_IDLE, ms_count: '0, lit: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign lit = state_ff.lit;

endmodule

// ===== ambient_checker_assertions.sv
/* Port checker for the ambient register bank.
   Assumes the bank's byte register port and a single clock domain. */
`timescale 1ns/10ps
`include "ambient_defs.svh"
module ambient_checker (
	input wire logic                clk,               // Clock.
	input wire logic                arst_n,            // Reset, active low.
	input wire logic [7:0]          reg_addr,          // Offset.
	input wire logic [7:0]          reg_wdata,         // Write data.
	input wire logic                reg_write,         // Write strobe.
	input wire logic                reg_read,          // Read strobe.
	input wire logic [7:0]          reg_rdata,         // Read data.
	input wire logic [`LIGHT_W-1:0] light_code,        // Light code.
	input wire logic                office_level_flag, // Office flag.
	input wire logic                dark_level_flag,   // Dark flag.
	input wire logic [2:0]          sink_drive,        // Sinks lit.
	input wire logic                fade_law_select,   // Fade law.
	input wire logic [3:0]          fade_in_time,      // Fade-in code.
	input wire logic [3:0]          fade_out_time      // Fade-out code.
);
	// ****
	// Shadow settings
	// ****
	logic [1:0] cen_ff;
	logic [6:0] otrip_ff;
	logic [6:0] ohys_ff;
	logic [6:0] dtrip_ff;
	logic [2:0] sen_ff;
	// Copies of the settings, updated on the same edge as the bank.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cen_ff <= 2'h0;
			otrip_ff <= 7'h00;
			ohys_ff <= 7'h00;
			dtrip_ff <= 7'h00;
			sen_ff <= 3'h0;
		end else if (reg_write) begin
			case (reg_addr)
			`OFS_COMPARATOR_CONFIG: cen_ff <= reg_wdata[1:0];
			`OFS_OFFICE_TRIP_LEVEL: otrip_ff <= reg_wdata[6:0];
			`OFS_OFFICE_HYSTERESIS: ohys_ff <= reg_wdata[6:0];
			`OFS_DARK_TRIP_LEVEL: dtrip_ff <= reg_wdata[6:0];
			`OFS_INDICATOR_SINK_CONTROL: sen_ff <= reg_wdata[2:0];
			default: sen_ff <= sen_ff;
			endcase
		end
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_office_flag_set: assert property (cen_ff[0] && light_code < {otrip_ff, 3'h0}
		|=> office_level_flag) else $error("office flag not set");
	a_office_flag_clear: assert property (cen_ff[0]
		&& light_code > {({1'b0, otrip_ff} + {1'b0, ohys_ff}), 3'h0}
		|=> !office_level_flag) else $error("office flag not cleared");
	a_dark_flag_set: assert property (cen_ff[1] && light_code < {5'h00, dtrip_ff}
		|=> dark_level_flag) else $error("dark flag not set");
	a_disabled_flag_low: assert property (!cen_ff[0] |=> !office_level_flag)
		else $error("disabled comparator flag high");
	a_flag_read_back: assert property (reg_read && reg_addr == `OFS_COMPARATOR_CONFIG
		|=> reg_rdata == {4'h0, $past(dark_level_flag), $past(office_level_flag), $past(cen_ff)})
		else $error("config read wrong");
	a_unmapped_read_zero: assert property (reg_read
		&& (reg_addr < `OFS_COMPARATOR_CONFIG || reg_addr > `OFS_INDICATOR_FADE_TIMES)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_fade_fields_follow: assert property (reg_write && reg_addr == `OFS_INDICATOR_FADE_TIMES
		|=> {fade_out_time, fade_in_time} == $past(reg_wdata)) else $error("fade codes wrong");
	a_fade_law_follow: assert property (reg_write && reg_addr == `OFS_INDICATOR_SINK_CONTROL
		|=> fade_law_select == $past(reg_wdata[3])) else $error("fade law wrong");
	a_sink_start_on: assert property (reg_write && reg_addr == `OFS_INDICATOR_SINK_CONTROL
		&& reg_wdata[0] && !sen_ff[0] |-> ##3 sink_drive[0]) else $error("sink not lit");
	a_sink_disable_off: assert property (reg_write && reg_addr == `OFS_INDICATOR_SINK_CONTROL
		&& reg_wdata[2:0] == 3'h0 |-> ##3 sink_drive == 3'h0) else $error("sinks not off");
endmodule

bind ambient_threshold_indicator_blink ambient_checker i_ambient_checker (
	.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.light_code(light_code), .office_level_flag(office_level_flag),
	.dark_level_flag(dark_level_flag), .sink_drive(sink_drive),
	.fade_law_select(fade_law_select), .fade_in_time(fade_in_time),
	.fade_out_time(fade_out_time));

// ===== host_model.sv
/* Host side of the byte register port: single-byte writes and reads.
   Assumes calls start 10 ns after a rising clock edge. */
`timescale 1ns/10ps
module host_model (
	input  wire logic       clk,       // Clock.
	input  wire logic [7:0] reg_rdata, // Read data.
	output logic      [7:0] reg_addr,  // Offset.
	output logic      [7:0] reg_wdata, // Write data.
	output logic            reg_write, // Write strobe.
	output logic            reg_read   // Read strobe.
);
	// Idle bus at time zero.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// One write; the released bus shows inverted values, then an idle cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clk);
		#10;
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		@(posedge clk);
		#10;
	endtask
	// One read; data is taken after the edge that accepted the strobe.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clk);
		#10;
		d = reg_rdata;
		reg_read = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#10;
	endtask
endmodule

// ===== tb_top.sv
/* Testbench for the ambient register bank and blink sequencers.
   Assumes host_model and the checker bind are compiled alongside. */
`timescale 1ns/10ps
`include "ambient_defs.svh"
module tb_top;
	localparam int P = 10;
	logic                clk;
	logic                arst_n;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic [7:0]          reg_rdata;
	logic                reg_write;
	logic                reg_read;
	logic [`LIGHT_W-1:0] light_code;
	logic                office_level_flag;
	logic                dark_level_flag;
	logic [2:0]          sink_drive;
	logic                fade_law_select;
	logic [3:0]          fade_in_time;
	logic [3:0]          fade_out_time;
	logic [7:0]          rv;
	int                  failures;
	int                  checks;

	ambient_threshold_indicator_blink #(.CYCLES_PER_MS(P)) i_ambient_threshold_indicator_blink (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.light_code(light_code), .office_level_flag(office_level_flag),
		.dark_level_flag(dark_level_flag), .sink_drive(sink_drive),
		.fade_law_select(fade_law_select), .fade_in_time(fade_in_time),
		.fade_out_time(fade_out_time));
	host_model i_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

	// 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ****
	// Common tasks
	// ****
	// Compares one value and counts the outcome.
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic close_out();
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Applies a light code and checks both flags one edge later.
	task automatic lt(input int v, input logic eo, input logic ed);
		light_code = v[`LIGHT_W-1:0];
		@(posedge clk);
		#10;
		check(office_level_flag, eo);
		check(dark_level_flag, ed);
	endtask
	// Counts cycles while sink 0 stays at one level, bounded.
	task automatic measure(input logic lvl, output int n);
		n = 0;
		while (sink_drive[0] === lvl) begin
			n++;
			if (n > 13000) begin
				failures++;
				$display("CHECK FAILED at %0t: sink phase too long", $time);
				close_out();
			end
			@(posedge clk);
			#10;
		end
	endtask
	// ****
	// Scenarios
	// ****
	// Reset values, write masks, unmapped place, fade and enable outputs.
	task automatic t_regs();
		logic [7:0] ofs [0:8];
		logic [7:0] msk [0:8];
		ofs = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h13, 8'h12, 8'h11, 8'h20};
		msk = '{8'h03, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'h0f, 8'h00};
		for (int i = 0; i < 9; i++) begin
			i_host_model.rd(ofs[i], rv);
			check(rv, 8'h00);
			i_host_model.wr(ofs[i], 8'hff);
			i_host_model.rd(ofs[i], rv);
			check(rv, msk[i]);
		end
		check(sink_drive, 3'h7);
		check(fade_law_select, 1'b1);
		i_host_model.wr(`OFS_INDICATOR_FADE_TIMES, 8'h5a);
		check({fade_out_time, fade_in_time}, 8'h5a);
		i_host_model.wr(`OFS_INDICATOR_SINK_CONTROL, 8'h00);
		@(posedge clk);
		#10;
		check(sink_drive, 3'h0);
		check(fade_law_select, 1'b0);
		i_host_model.wr(`OFS_COMPARATOR_CONFIG, 8'h00);
	endtask
	// Office comparator at its trip and clear boundaries.
	task automatic t_office();
		int s;
		s = `OFFICE_STEP_NA / `SENSOR_STEP_NA;
		i_host_model.wr(`OFS_OFFICE_TRIP_LEVEL, 8'h0a);
		i_host_model.wr(`OFS_OFFICE_HYSTERESIS, 8'h02);
		i_host_model.wr(`OFS_COMPARATOR_CONFIG, 8'h01);
		lt(10 * s - 1, 1'b1, 1'b0);
		lt(12 * s, 1'b1, 1'b0);
		lt(12 * s + 1, 1'b0, 1'b0);
		lt(10 * s, 1'b0, 1'b0);
		lt(10 * s - 1, 1'b1, 1'b0);
		i_host_model.rd(`OFS_COMPARATOR_CONFIG, rv);
		check(rv, 8'h05);
		i_host_model.wr(`OFS_COMPARATOR_CONFIG, 8'h00);
		check(office_level_flag, 1'b0);
	endtask
	// Dark comparator at its trip and clear boundaries.
	task automatic t_dark();
		int s;
		s = `DARK_STEP_NA / `SENSOR_STEP_NA;
		i_host_model.wr(`OFS_DARK_TRIP_LEVEL, 8'h14);
		i_host_model.wr(`OFS_DARK_HYSTERESIS, 8'h05);
		i_host_model.wr(`OFS_COMPARATOR_CONFIG, 8'h02);
		lt(20 * s - 1, 1'b0, 1'b1);
		lt(25 * s, 1'b0, 1'b1);
		i_host_model.rd(`OFS_COMPARATOR_CONFIG, rv);
		check(rv, 8'h0a);
		lt(25 * s + 1, 1'b0, 1'b0);
		lt(20 * s, 1'b0, 1'b0);
	endtask
	// Every on-time and off-time code; sinks 1 and 2 stay steady.
	task automatic t_blink();
		int n;
		int onms [0:3];
		int offms [0:3];
		logic [1:0] k;
		onms = '{`ON_TIME0_MS, `ON_TIME1_MS, `ON_TIME2_MS, `ON_TIME3_MS};
		offms = '{`OFF_TIME1_MS, `OFF_TIME1_MS, `OFF_TIME2_MS, `OFF_TIME3_MS};
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			i_host_model.wr(`OFS_INDICATOR_BLINK_TIMES, {k, 4'h0, (k == 2'h0) ? 2'h1 : k});
			i_host_model.wr(`OFS_INDICATOR_SINK_CONTROL, 8'h07);
			@(posedge clk);
			#10;
			check(sink_drive, 3'h7);
			measure(1'b1, n);
			check(n >= (onms[i] - 1) * P - 3 && n <= onms[i] * P + 1, 1'b1);
			check(sink_drive[2:1], 2'h3);
			measure(1'b0, n);
			check(n >= offms[i] * P - 1 && n <= offms[i] * P + 1, 1'b1);
			i_host_model.wr(`OFS_INDICATOR_SINK_CONTROL, 8'h00);
			@(posedge clk);
			#10;
			check(sink_drive, 3'h0);
		end
	endtask
	// Main sequence.
	initial begin
		failures = 0;
		checks = 0;
		arst_n = 1'b0;
		light_code = 12'hfa0;
		repeat (6) @(posedge clk);
		#10;
		arst_n = 1'b1;
		t_regs();
		t_office();
		t_dark();
		t_blink();
		close_out();
	end
endmodule
